// ==== pkg/eeprom_defs.svh ====
// Contract
// RL1 - Sample on clock rise, drive on fall
// RL2 - Data changes only while clock low
// RL3 - Data falling, clock high: start
// RL4 - Data rising, clock high: stop, standby
// RL5 - Stop after write launches timed programming
// RL6 - Acknowledge low on ninth clock pulse
// RL7 - Standby after reset, read stop, programming
// RL8 - Start, eighteen ones, start resets protocol
// RL9 - Device type must be 1010 or 1011
// RL10 - Select bits must match stored code
// RL11 - Select code loaded at power-on
// RL12 - Last device bit chooses read or write
// RL13 - Thirteen-bit address, high byte first
// RL14 - Byte write: device, two addresses, data
// RL15 - Ignore the bus while programming runs
// RL16 - Up to 32 data bytes per page
// RL17 - Only low five address bits increment
// RL18 - Programming completes within five milliseconds
// RL19 - Busy device withholds device byte acknowledge
// RL20 - Identification page uses selector bits 00
// RL21 - Selector 01 byte write replaces select code
// RL22 - High address bit writes protect register
// RL23 - Block field sets protected lower bound
// RL24 - Protected address: no acknowledge, no write
// RL25 - Data line only pulled low or released
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH

`define TYPE_ARRAY          4'hA
`define TYPE_ID             4'hB
`define SELECT_CODE_RESET   3'h0
`define ID_SEL_PAGE         2'h0
`define ID_SEL_CODE         2'h1
`define BYTE_LAST_BIT       4'h8
`define ACK_LAST_BIT        4'h9
`define FIFO_DEPTH          32
`define PROG_TIME_NS        5000000
`define CLK_PERIOD_NS       100

`endif

// ==== pkg/eeprom_pkg.sv ====
package eeprom_pkg;

   typedef struct packed
   {
      logic        id_page;
      logic [12:0] addr;
      logic [7:0]  data;
   } mem_write_t;

   typedef struct packed
   {
      logic protect_enable_bit;
      logic block_protect_high_bit;
      logic block_protect_low_bit;
   } protect_cfg_t;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,
      ST_DEV  = 3'h1,
      ST_HI   = 3'h3,
      ST_LO   = 3'h2,
      ST_DATA = 3'h6,
      ST_SKIP = 3'h7
   } link_state_t;

endpackage

// ==== src/serial_eeprom_two_wire_slave.sv ====
`timescale 1ns/1ps
`include "eeprom_defs.svh"

// ========
// Write buffer
module write_fifo
#(
   parameter int unsigned WIDTH = 22,
   parameter int unsigned DEPTH = `FIFO_DEPTH
)
(
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             ce,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);

   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic             full;
   logic             empty;

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      begin : g_check
         $error("write_fifo depth must be a power of two");
      end
   endgenerate

   assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign empty     = (wr_ptr == rd_ptr);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = store[rd_ptr[AW-1:0]];

   always_ff @(posedge clock)
   begin
      if (ce && in_valid && !full)
      begin
         store[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else if (ce)
      begin
         if (in_valid && !full)
         begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (out_ready && !empty)
         begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

endmodule

// ========
// Two-wire slave
module serial_eeprom_two_wire_slave
#(
   parameter int unsigned PROG_CYCLES = `PROG_TIME_NS / `CLK_PERIOD_NS,
   parameter int unsigned FIFO_DEPTH  = `FIFO_DEPTH
)
(
   // Clock and reset
   input  wire logic                      clock,
   input  wire logic                      rst_n,
   input  wire logic                      ce,
   // Two-wire pins
   input  wire logic                      scl_in,
   input  wire logic                      sda_in,
   output logic                           sda_o,
   output logic                           sda_oe,
   // Non-volatile values at power-on
   input  wire logic [2:0]                select_code_nv,
   input  wire eeprom_pkg::protect_cfg_t  protect_nv,
   // Status
   output logic [2:0]                     stored_select_code,
   output eeprom_pkg::protect_cfg_t       protect_config_register,
   output logic                           busy,
   // Array write port
   output logic                           mem_wr_valid,
   input  wire logic                      mem_wr_ready,
   output eeprom_pkg::mem_write_t         mem_wr
);

   import eeprom_pkg::*;

   generate
      if (PROG_CYCLES < 1)
      begin : g_check
         $error("PROG_CYCLES must be at least one");
      end
   endgenerate

   logic [2:0]   scl_sync;
   logic [2:0]   sda_sync;
   logic         scl_rise;
   logic         scl_fall;
   logic         start_seen;
   logic         stop_seen;

   link_state_t  state;
   link_state_t  next_state;
   logic [3:0]   bit_cnt;
   logic [7:0]   shreg;
   logic         byte_end;
   logic         ack_end;
   logic         ack_ok;

   logic         id_space;
   logic [7:0]   addr_hi;
   logic [7:0]   addr_lo;
   logic [1:0]   data_count;
   logic         wrote_array;
   logic [2:0]   pend_code;
   logic [2:0]   pend_prot;
   logic         commit_code;
   logic         commit_prot;
   logic         loaded;

   logic [1:0]   id_sel;
   logic         prot_access;
   logic [12:0]  array_addr;
   logic         in_protected;
   logic         push;
   mem_write_t   push_data;
   logic         fifo_ready;
   logic         fifo_out_valid;
   logic         fifo_out_ready;
   mem_write_t   fifo_out;

   logic [31:0]  prog_timer;
   logic         prog_launch;
   logic         prog_done;

   // ========
   // Pin synchronisers and bus conditions
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
      end
      else if (ce)
      begin
         scl_sync <= {scl_sync[1:0], scl_in};
         sda_sync <= {sda_sync[1:0], sda_in};
      end
   end

   assign scl_rise   = scl_sync[1] && !scl_sync[2];
   assign scl_fall   = !scl_sync[1] && scl_sync[2];
   // Data edge while clock stays high
   assign start_seen = scl_sync[1] && scl_sync[2] && !sda_sync[1] && sda_sync[2]; // [RL3] [RL2]
   assign stop_seen  = scl_sync[1] && scl_sync[2] && sda_sync[1] && !sda_sync[2]; // [RL4] [RL2]

   assign byte_end = scl_fall && (bit_cnt == `BYTE_LAST_BIT);
   assign ack_end  = scl_fall && (bit_cnt == `ACK_LAST_BIT);

   // ========
   // Byte decode
   assign id_sel       = addr_hi[2:1];
   assign prot_access  = !id_space && addr_hi[7];
   assign array_addr   = {addr_hi[4:0], addr_lo};
   assign in_protected = protect_config_register.protect_enable_bit &&
                         (array_addr[12:11] >= (2'h3 - {protect_config_register.block_protect_high_bit,
                                                        protect_config_register.block_protect_low_bit})); // [RL23]

   always_comb
   begin
      next_state = state;
      ack_ok     = 1'b0;
      push       = 1'b0;
      push_data  = '0;
      unique case (state)
         ST_DEV:
         begin
            // Type and select code must both match
            if ((shreg[7:4] == `TYPE_ARRAY || shreg[7:4] == `TYPE_ID) &&
                shreg[3:1] == stored_select_code) // [RL9] [RL10]
            begin
               ack_ok     = 1'b1;
               next_state = shreg[0] ? ST_SKIP : ST_HI; // [RL12]
            end
            else
            begin
               next_state = ST_SKIP; // [RL10]
            end
         end
         ST_HI:
         begin
            ack_ok     = 1'b1;
            next_state = ST_LO; // [RL13]
         end
         ST_LO:
         begin
            ack_ok     = 1'b1;
            next_state = ST_DATA;
         end
         ST_DATA:
         begin
            if (id_space)
            begin
               if (id_sel == `ID_SEL_PAGE)
               begin
                  push              = fifo_ready; // [RL20]
                  ack_ok            = fifo_ready;
                  push_data.id_page = 1'b1;
                  push_data.addr    = {8'h00, addr_lo[4:0]};
                  push_data.data    = shreg;
               end
               else if (id_sel == `ID_SEL_CODE)
               begin
                  ack_ok = 1'b1; // [RL21]
               end
            end
            else if (prot_access)
            begin
               ack_ok = 1'b1; // [RL22]
            end
            else if (!in_protected)
            begin
               push              = fifo_ready; // [RL14] [RL16]
               ack_ok            = fifo_ready;
               push_data.id_page = 1'b0;
               push_data.addr    = array_addr;
               push_data.data    = shreg;
            end
         end
         ST_IDLE, ST_SKIP:
         begin
            next_state = state;
         end
      endcase
   end

   // ========
   // Protocol state
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state   <= ST_IDLE; // [RL7]
         bit_cnt <= 4'h0;
         shreg   <= 8'h00;
      end
      else if (ce)
      begin
         if (busy)
         begin
            state   <= ST_IDLE; // [RL15] [RL19]
            bit_cnt <= 4'h0;
         end
         else if (start_seen)
         begin
            state   <= ST_DEV; // [RL8]
            bit_cnt <= 4'h0;
         end
         else if (stop_seen)
         begin
            state   <= ST_IDLE; // [RL4]
            bit_cnt <= 4'h0;
         end
         else if (state != ST_IDLE)
         begin
            if (scl_rise && bit_cnt < `ACK_LAST_BIT)
            begin
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt < `BYTE_LAST_BIT)
               begin
                  shreg <= {shreg[6:0], sda_sync[1]}; // [RL1] [RL6]
               end
            end
            if (byte_end)
            begin
               state <= next_state;
            end
            if (ack_end)
            begin
               bit_cnt <= 4'h0;
            end
         end
      end
   end

   // ========
   // Acknowledge drive
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sda_oe <= 1'b0;
         sda_o  <= 1'b0;
      end
      else if (ce)
      begin
         sda_o <= 1'b0; // [RL25]
         if (busy || start_seen || stop_seen || ack_end)
         begin
            sda_oe <= 1'b0;
         end
         else if (byte_end && state != ST_IDLE)
         begin
            sda_oe <= ack_ok; // [RL1] [RL6] [RL24]
         end
      end
   end

   // ========
   // Address and pending updates
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         id_space    <= 1'b0;
         addr_hi     <= 8'h00;
         addr_lo     <= 8'h00;
         data_count  <= 2'h0;
         wrote_array <= 1'b0;
         pend_code   <= `SELECT_CODE_RESET;
         pend_prot   <= 3'h0;
      end
      else if (ce && !busy)
      begin
         if (start_seen)
         begin
            data_count  <= 2'h0;
            wrote_array <= 1'b0;
         end
         else if (byte_end)
         begin
            unique case (state)
               ST_DEV:
               begin
                  id_space <= (shreg[7:4] == `TYPE_ID);
               end
               ST_HI:
               begin
                  addr_hi <= shreg; // [RL13]
               end
               ST_LO:
               begin
                  addr_lo <= shreg;
               end
               ST_DATA:
               begin
                  if (ack_ok)
                  begin
                     if (data_count != 2'h2)
                     begin
                        data_count <= data_count + 2'h1;
                     end
                     // Page row held, low five bits wrap
                     addr_lo[4:0] <= addr_lo[4:0] + 5'h01; // [RL17]
                  end
                  if (push)
                  begin
                     wrote_array <= 1'b1;
                  end
                  pend_code <= shreg[2:0]; // [RL21]
                  pend_prot <= shreg[3:1]; // [RL22]
               end
               ST_IDLE, ST_SKIP:
               begin
                  data_count <= data_count;
               end
            endcase
         end
      end
   end

   // ========
   // Programming cycle
   assign commit_code = (state == ST_DATA) && id_space && (id_sel == `ID_SEL_CODE) && (data_count == 2'h1);
   assign commit_prot = (state == ST_DATA) && prot_access && (data_count == 2'h1); // [RL22]
   assign prog_launch = !busy && stop_seen && (state == ST_DATA) &&
                        (wrote_array || commit_code || commit_prot); // [RL5] [RL14]
   assign prog_done   = busy && (prog_timer >= 32'(PROG_CYCLES - 1)) &&
                        !fifo_out_valid && !mem_wr_valid; // [RL18]

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy       <= 1'b0;
         prog_timer <= 32'h0;
      end
      else if (ce)
      begin
         if (prog_launch)
         begin
            busy       <= 1'b1; // [RL5]
            prog_timer <= 32'h0;
         end
         else if (prog_done)
         begin
            busy <= 1'b0; // [RL7]
         end
         else if (busy && prog_timer < 32'(PROG_CYCLES - 1))
         begin
            prog_timer <= prog_timer + 32'h1;
         end
      end
   end

   logic launch_code;
   logic launch_prot;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         launch_code <= 1'b0;
         launch_prot <= 1'b0;
      end
      else if (ce)
      begin
         if (prog_launch)
         begin
            launch_code <= commit_code;
            launch_prot <= commit_prot;
         end
         else if (prog_done)
         begin
            launch_code <= 1'b0;
            launch_prot <= 1'b0;
         end
      end
   end

   // ========
   // Stored select code and protect register
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         loaded                  <= 1'b0;
         stored_select_code      <= `SELECT_CODE_RESET;
         protect_config_register <= '0;
      end
      else if (ce)
      begin
         if (!loaded)
         begin
            loaded                  <= 1'b1;
            stored_select_code      <= select_code_nv; // [RL11]
            protect_config_register <= protect_nv;
         end
         else if (prog_done)
         begin
            if (launch_code)
            begin
               stored_select_code <= pend_code; // [RL21]
            end
            if (launch_prot)
            begin
               protect_config_register <= pend_prot; // [RL22]
            end
         end
      end
   end

   // ========
   // Write buffer and array port
   write_fifo
   #(
      .WIDTH ($bits(mem_write_t)),
      .DEPTH (FIFO_DEPTH)
   )
   u_fifo
   (
      .clock     (clock),
      .rst_n     (rst_n),
      .ce        (ce),
      .in_valid  (push && byte_end && !busy),
      .in_ready  (fifo_ready),
      .in_data   (push_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out)
   );

   assign fifo_out_ready = !mem_wr_valid || mem_wr_ready;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_wr_valid <= 1'b0;
         mem_wr       <= '0;
      end
      else if (ce && fifo_out_ready)
      begin
         mem_wr_valid <= fifo_out_valid;
         mem_wr       <= fifo_out;
      end
   end

endmodule

// ==== verif/bus_master.sv ====
`timescale 1ns/1ps
// ========
// Two-wire bus master model, one SCL period is eight clocks
module bus_master
(
   // Clock
   input  wire logic clock,
   // Bus
   input  wire logic sda_bus,
   output logic      scl,
   output logic      sda_pull
);
   initial {scl, sda_pull} = 2'b10;

   task automatic quarter();
      repeat (2) @(posedge clock);
   endtask

   task automatic start();
      sda_pull <= 1'b0;
      quarter();
      scl <= 1'b1;
      quarter();
      sda_pull <= 1'b1;
      quarter();
      scl <= 1'b0;
      quarter();
   endtask

   // Extra free time after the stop
   task automatic stop();
      sda_pull <= 1'b1;
      quarter();
      scl <= 1'b1;
      quarter();
      sda_pull <= 1'b0;
      repeat (3) quarter();
   endtask

   // Data set while clock low, sampled mid high phase
   task automatic bit_xfer(input logic b, output logic seen);
      sda_pull <= !b;
      quarter();
      scl <= 1'b1;
      quarter();
      @(negedge clock);
      seen = sda_bus;
      quarter();
      scl <= 1'b0;
      quarter();
   endtask

   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic seen;
      for (int i = 7; i >= 0; i--)
         bit_xfer(d[i], seen);
      bit_xfer(1'b1, seen);
      ack = !seen;
   endtask

   task automatic soft_reset();
      logic seen;
      start();
      repeat (18) bit_xfer(1'b1, seen);
      start();
   endtask
endmodule

// ==== verif/serial_eeprom_two_wire_slave_asserts.sv ====
`timescale 1ns/1ps
// ========
// Protocol checker
module serial_eeprom_two_wire_slave_asserts
#(
   parameter int unsigned PROG_CYCLES = 50000,
   parameter int unsigned FIFO_DEPTH  = 32
)
(
   // Clock and reset
   input wire logic                     clock,
   input wire logic                     rst_n,
   input wire logic                     ce,
   // Two-wire pins
   input wire logic                     scl_in,
   input wire logic                     sda_in,
   input wire logic                     sda_o,
   input wire logic                     sda_oe,
   // Non-volatile values
   input wire logic [2:0]               select_code_nv,
   input wire eeprom_pkg::protect_cfg_t protect_nv,
   // Status
   input wire logic [2:0]               stored_select_code,
   input wire eeprom_pkg::protect_cfg_t protect_config_register,
   input wire logic                     busy,
   // Array write port
   input wire logic                     mem_wr_valid,
   input wire logic                     mem_wr_ready,
   input wire eeprom_pkg::mem_write_t   mem_wr
);
   import eeprom_pkg::*;

   int unsigned busy_cnt;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         busy_cnt <= 0;
      else if (busy)
         busy_cnt <= busy_cnt + 1;
      else
         busy_cnt <= 0;
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   sequence ack_held;
      sda_oe [*6];
   endsequence

   chk_open_drain_only: assert property (!sda_o)
      else $error("data line driven high");
   chk_ack_one_bit: assert property ($rose(sda_oe) |-> ack_held ##[1:6] !sda_oe)
      else $error("ack width");
   chk_ack_scl_low: assert property ($rose(sda_oe) |-> !$past(scl_in, 2))
      else $error("ack rose, clock high");
   chk_release_scl_low: assert property ($fell(sda_oe) |-> !$past(scl_in, 2))
      else $error("ack fell, clock high");
   chk_quiet_while_busy: assert property (busy |-> !sda_oe)
      else $error("answer while programming");
   chk_busy_min_span: assert property ($rose(busy) |-> busy [*8])
      else $error("programming too short");
   chk_busy_bounded: assert property (busy_cnt <= PROG_CYCLES + 2 * FIFO_DEPTH + 8)
      else $error("programming too long");
   chk_beat_held: assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr))
      else $error("write beat dropped");
   chk_protect_blocks_beat: assert property (mem_wr_valid && protect_config_register.protect_enable_bit
      && !mem_wr.id_page |-> mem_wr.addr[12:11] < 2'h3 - {protect_config_register.block_protect_high_bit,
      protect_config_register.block_protect_low_bit})
      else $error("protected address written");
   chk_nv_loaded: assert property ($rose(rst_n) |=> stored_select_code == select_code_nv
      && protect_config_register == protect_nv)
      else $error("power-on values not loaded");
   chk_code_on_finish: assert property ($changed(stored_select_code) && $past(rst_n, 2) |-> $fell(busy))
      else $error("code changed off finish");
   chk_protect_on_finish: assert property ($changed(protect_config_register) && $past(rst_n, 2) |-> $fell(busy))
      else $error("protect changed off finish");
endmodule

bind serial_eeprom_two_wire_slave serial_eeprom_two_wire_slave_asserts
#(.PROG_CYCLES(PROG_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) i_serial_eeprom_two_wire_slave_asserts
(.*);

// ==== verif/serial_eeprom_two_wire_slave_test.sv ====
`timescale 1ns/1ps
// ========
// Self-checking bench
module serial_eeprom_two_wire_slave_test;
   import eeprom_pkg::*;
   localparam int unsigned PROG = 400;
   logic         clock;
   logic         rst_n;
   logic         mem_wr_ready;
   logic         scl;
   logic         pull;
   logic         sda_o;
   logic         sda_oe;
   logic         busy;
   logic         mem_wr_valid;
   logic [2:0]   stored_select_code;
   logic [2:0]   code;
   protect_cfg_t protect_config_register;
   mem_write_t   mem_wr;
   mem_write_t   beats[$];
   int           errors;
   int           n_tests;
   wire          sda = !(pull || (sda_oe && !sda_o));

   bus_master i_bus_master (.clock(clock), .sda_bus(sda), .scl(scl), .sda_pull(pull));

   serial_eeprom_two_wire_slave #(.PROG_CYCLES(PROG), .FIFO_DEPTH(32)) i_serial_eeprom_two_wire_slave
   (.ce(1'b1), .scl_in(scl), .sda_in(sda), .select_code_nv(3'h5), .protect_nv(3'h0), .*);

   always #50 clock = ~clock;

   always @(posedge clock)
      if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1)
         beats.push_back(mem_wr);

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic done(input string what);
      $display("%s finished", what);
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      @(negedge clock);
      while (busy !== 1'b0 && n < PROG + 200)
      begin
         @(negedge clock);
         n++;
      end
      check("busy ends", busy, 1'b0);
      @(posedge clock);
   endtask

   task automatic head(input logic [3:0] t, input logic [7:0] hi, input logic [7:0] lo, output logic [2:0] a);
      i_bus_master.start();
      i_bus_master.send_byte({t, code, 1'b0}, a[2]);
      i_bus_master.send_byte(hi, a[1]);
      i_bus_master.send_byte(lo, a[0]);
   endtask

   task automatic wr(input logic [3:0] t, input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] d,
                     output logic p);
      logic [2:0] a;
      head(t, hi, lo, a);
      check("head acks", a, 3'h7);
      i_bus_master.send_byte(d, p);
      i_bus_master.stop();
      wait_idle();
   endtask

   task automatic t_byte_write();
      logic [2:0] a;
      logic       p;
      beats.delete();
      head(4'hA, 8'h61, 8'h23, a);
      check("head acks", a, 3'h7);
      i_bus_master.send_byte(8'h5A, p);
      check("data ack", p, 1'b1);
      i_bus_master.stop();
      @(negedge clock);
      check("busy on stop", busy, 1'b1);
      i_bus_master.start();
      i_bus_master.send_byte({4'hA, code, 1'b0}, p);
      check("poll while busy", p, 1'b0);
      i_bus_master.stop();
      wait_idle();
      check("beat count", beats.size(), 1);
      check("byte beat", beats[0], {1'b0, 13'h0123, 8'h5A});
      i_bus_master.start();
      i_bus_master.send_byte({4'hA, code, 1'b0}, p);
      check("poll idle", p, 1'b1);
      i_bus_master.stop();
      done("byte write");
   endtask

   task automatic t_device_select();
      logic [7:0] cmd [5];
      logic [4:0] exp;
      logic       p;
      cmd = '{8'h9A, {4'hA, ~code, 1'b0}, 8'hEA, {4'hB, code, 1'b0}, {4'hA, code, 1'b1}};
      exp = 5'h03;
      for (int i = 0; i < 5; i++)
      begin
         i_bus_master.start();
         i_bus_master.send_byte(cmd[i], p);
         check("device ack", p, exp[4 - i]);
         i_bus_master.stop();
      end
      done("device select");
   endtask

   task automatic t_page_stall();
      logic [2:0] a;
      logic       p;
      int         n;
      n = 0;
      beats.delete();
      mem_wr_ready <= 1'b0;
      head(4'hA, 8'h00, 8'h3E, a);
      for (int i = 0; i < 34; i++)
      begin
         i_bus_master.send_byte(8'(i), p);
         if (p === 1'b1)
            n++;
      end
      check("refused when full", n < 34, 1'b1);
      check("page accepted", n >= 32, 1'b1);
      i_bus_master.stop();
      mem_wr_ready <= 1'b1;
      wait_idle();
      check("drained", beats.size(), n);
      for (int i = 0; i < n; i++)
         check("page beat", beats[i], {1'b0, 8'h01, 5'(30 + i), 8'(i)});
      done("page stall");
   endtask

   task automatic t_id_page();
      logic p;
      beats.delete();
      wr(4'hB, 8'hF8, 8'hE5, 8'h3C, p);
      check("id data ack", p, 1'b1);
      check("id beat", {beats[0].id_page, beats[0].addr[4:0], beats[0].data}, {1'b1, 5'h05, 8'h3C});
      done("id page");
   endtask

   task automatic t_select_code();
      logic p;
      wr(4'hB, 8'h02, 8'h00, 8'hFB, p);
      check("code data ack", p, 1'b1);
      check("new code", stored_select_code, 3'h3);
      i_bus_master.start();
      i_bus_master.send_byte({4'hA, code, 1'b0}, p);
      check("old code refused", p, 1'b0);
      i_bus_master.stop();
      code = 3'h3;
      done("select code");
   endtask

   task automatic t_protect();
      logic [12:0] bound;
      logic [2:0]  a;
      logic        p;
      for (int b = 0; b < 4; b++)
      begin
         wr(4'hA, 8'h80, 8'h00, {4'hF, 1'b1, 2'(b), 1'b1}, p);
         check("protect reg", protect_config_register, {1'b1, 2'(b)});
         bound = 13'h1800 - 13'(b) * 13'h0800;
         wr(4'hA, {3'h0, bound[12:8]}, bound[7:0], 8'h77, p);
         check("protected refused", p, 1'b0);
         if (b < 3)
         begin
            bound = bound - 13'h0001;
            wr(4'hA, {3'h0, bound[12:8]}, bound[7:0], 8'h77, p);
            check("below bound", p, 1'b1);
         end
      end
      head(4'hA, 8'h80, 8'h00, a);
      i_bus_master.send_byte(8'h00, p);
      i_bus_master.send_byte(8'h00, p);
      i_bus_master.stop();
      wait_idle();
      check("multi byte ignored", protect_config_register, 3'h7);
      wr(4'hA, 8'h80, 8'h00, 8'h00, p);
      check("protect off", protect_config_register, 3'h0);
      done("protect");
   endtask

   task automatic t_soft_reset();
      logic p;
      logic seen;
      i_bus_master.start();
      i_bus_master.send_byte({4'hA, code, 1'b0}, p);
      i_bus_master.bit_xfer(1'b0, seen);
      i_bus_master.bit_xfer(1'b1, seen);
      i_bus_master.soft_reset();
      i_bus_master.send_byte({4'hA, code, 1'b0}, p);
      check("ack after soft reset", p, 1'b1);
      i_bus_master.stop();
      done("soft reset");
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (80000) @(posedge clock);
      errors++;
      give_verdict();
   end

   initial
   begin
      clock = 1'b0;
      rst_n = 1'b0;
      mem_wr_ready = 1'b1;
      code = 3'h5;
      errors = 0;
      n_tests = 0;
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      @(negedge clock);
      check("loaded code", stored_select_code, 3'h5);
      check("idle busy", busy, 1'b0);
      @(posedge clock);
      t_byte_write();
      t_device_select();
      t_page_stall();
      t_id_page();
      t_select_code();
      t_protect();
      t_soft_reset();
      give_verdict();
   end
endmodule
